// file: hdl/pwm_amplitude_regulator.sv
/*
 * Voltage PWM amplitude regulator for one motor: automatic proportional
 * scaling from sensed coil current, or fixed user amplitude.
 * Assumes current sample, target, velocity compare and standstill are
 * synchronous to clk and prepared by the chopper around it.
 */
`timescale 1ns/10ps
`include "pwm_regulator_cfg.svh"

module pwm_amplitude_regulator
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // configuration
    input wire logic pwm_autoscale,
    input wire logic [`GRAD_W-1:0] regulation_gradient,
    input wire logic [`SCALE_W-1:0] user_pwm_amplitude,
    input wire logic [`FREQ_W-1:0] pwm_frequency_select,
    input wire logic [`BLANK_W-1:0] blank_time_select,
    // motion state
    input wire logic below_switch_velocity,
    input wire logic standstill,
    // current feedback
    input wire logic [`CUR_W-1:0] coil_current,
    input wire logic [`CUR_W-1:0] target_current,
    // status and drive
    output logic [`SCALE_W-1:0] pwm_scale,
    output logic [`SCALE_W-1:0] sine_peak,
    output logic voltage_mode_active,
    output logic regulation_started,
    output logic pwm_on,
    output logic period_tick
);

    typedef struct packed
    {
        logic [`SCALE_W-1:0] scale;
        logic started;
        logic active;
        logic [7:0] still_cnt;
    } reg_s;

    reg_s s_q;
    reg_s s_d;
    logic sample;
    logic enabled;
    logic in_voltage;
    logic signed [`ERR_W-1:0] err;
    logic signed [`ERR_W-1:0] acc;
    pwm_regulator_pkg::chop_mode_e mode;

    pwm_period_gen u_gen
    (
        .clk(clk),
        .rst_n(rst_n),
        .pwm_frequency_select(pwm_frequency_select),
        .blank_time_select(blank_time_select),
        .duty(s_q.scale),
        .period_tick(period_tick),
        .sample_strobe(sample),
        .pwm_on(pwm_on)
    );

    always_comb
    begin
        enabled = (regulation_gradient != `GRAD_OFF);
        in_voltage = enabled && below_switch_velocity;
        if (!enabled)
            mode = pwm_regulator_pkg::MODE_OFF;
        else if (in_voltage)
            mode = pwm_regulator_pkg::MODE_VOLTAGE;
        else
            mode = pwm_regulator_pkg::MODE_CURRENT;
        // proportional step, gain straight from the gradient
        err = $signed({9'h000, target_current})
            - $signed({9'h000, coil_current});
        acc = $signed({9'h000, s_q.scale})
            + err * $signed({13'h0000, regulation_gradient});
    end

    always_comb
    begin
        s_d = s_q;
        s_d.active = in_voltage;
        if (period_tick)
        begin
            if (standstill && s_q.still_cnt != `STILL_PERIODS)
                s_d.still_cnt = s_q.still_cnt + 8'h01;
            else if (!standstill)
                s_d.still_cnt = 8'h00;
        end
        case (mode)
            pwm_regulator_pkg::MODE_VOLTAGE:
            begin
                if (!s_q.active)
                    s_d.scale = user_pwm_amplitude;
                else if (!pwm_autoscale)
                begin
                    s_d.scale = user_pwm_amplitude;
                    s_d.started = 1'b0;
                end
                else if (!s_q.started)
                begin
                    // no start-up during motion: current would stay zero
                    if (standstill)
                        s_d.started = 1'b1;
                end
                else if (sample)
                begin
                    // a collapsed scale sticks, moving or not: zero duty gives no sample,
                    // so this standstill re-arm from the user amplitude never fires
                    if (s_q.scale == `SCALE_RESET && standstill)
                        s_d.scale = user_pwm_amplitude;
                    else if (acc > $signed({9'h000, `SCALE_MAX}))
                        s_d.scale = `SCALE_MAX;
                    else if (acc < 0)
                        s_d.scale = `SCALE_RESET;
                    else
                        s_d.scale = acc[`SCALE_W-1:0];
                end
            end
            pwm_regulator_pkg::MODE_CURRENT:
                ; // last scale held; re-entry reloads the user amplitude
            pwm_regulator_pkg::MODE_OFF:
            begin
                s_d.started = 1'b0;
                s_d.scale = `SCALE_RESET;
            end
            default:
                s_d = s_q;
        endcase
        if (!rst_n)
            s_d = '0;
    end

    always_ff @(posedge clk)
        s_q <= s_d;

    assign pwm_scale = s_q.scale;
    assign sine_peak = `SINE_PEAK;
    assign voltage_mode_active = s_q.active;
    assign regulation_started = s_q.started;

endmodule : pwm_amplitude_regulator

// file: hdl/pwm_period_gen.sv
/*
 * Voltage PWM carrier: triangle counter, period tick and on-phase sample
 * strobe after blanking. Assumes one 10 MHz clock, synchronous reset.
 */
`timescale 1ns/10ps
`include "pwm_regulator_cfg.svh"

module pwm_period_gen
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // configuration
    input wire logic [`FREQ_W-1:0] pwm_frequency_select,
    input wire logic [`BLANK_W-1:0] blank_time_select,
    input wire logic [`SCALE_W-1:0] duty,
    // carrier events
    output logic period_tick,
    output logic sample_strobe,
    output logic pwm_on
);

    typedef struct packed
    {
        logic [`PERIOD_W-1:0] cnt;
        logic down;
        logic tick;
        logic sample;
        logic on;
    } gen_s;

    gen_s s_q;
    gen_s s_d;
    logic [`PERIOD_W-1:0] half;
    logic [`PERIOD_W-1:0] blank;
    logic [`PERIOD_W+`SCALE_W-1:0] prod;
    logic [`PERIOD_W-1:0] on_len;

    always_comb
    begin
        case (pwm_frequency_select)
            2'h0: half = `HALF_PERIOD_0;
            2'h1: half = `HALF_PERIOD_1;
            2'h2: half = `HALF_PERIOD_2;
            default: half = `HALF_PERIOD_3;
        endcase
        case (blank_time_select)
            2'h0: blank = `BLANK_CYCLES_0;
            2'h1: blank = `BLANK_CYCLES_1;
            2'h2: blank = `BLANK_CYCLES_2;
            default: blank = `BLANK_CYCLES_3;
        endcase
        prod = half * duty;
        on_len = prod[`PERIOD_W+`SCALE_W-1:`SCALE_W];
    end

    always_comb
    begin
        s_d = s_q;
        s_d.tick = 1'b0;
        s_d.sample = 1'b0;
        if (s_q.down)
        begin
            if (s_q.cnt == '0)
            begin
                s_d.down = 1'b0;
                s_d.tick = 1'b1;
            end
            else
                s_d.cnt = s_q.cnt - 1'b1;
        end
        else if (s_q.cnt >= half - 1'b1)
            s_d.down = 1'b1;
        else
            s_d.cnt = s_q.cnt + 1'b1;
        s_d.on = (s_q.cnt < on_len);
        // current is only valid after blanking; short on-times never sample
        s_d.sample = s_q.down && (s_q.cnt == '0) && (on_len > blank);
        if (!rst_n)
            s_d = '0;
    end

    always_ff @(posedge clk)
        s_q <= s_d;

    assign period_tick = s_q.tick;
    assign sample_strobe = s_q.sample;
    assign pwm_on = s_q.on;

endmodule : pwm_period_gen

// file: hdl/pwm_regulator_cfg.svh
/*
 * Constants of the voltage PWM amplitude regulator: widths, codes, counts.
 * Assumes a 10 MHz system clock and inclusion by bare name.
 */
`ifndef PWM_REGULATOR_CFG_SVH
`define PWM_REGULATOR_CFG_SVH

`define SCALE_W 8
`define SCALE_MAX 8'hFF
`define SCALE_RESET 8'h00
`define SINE_PEAK 8'hF8
`define GRAD_W 4
`define GRAD_OFF 4'h0
`define FREQ_W 2
`define PERIOD_W 11
`define HALF_PERIOD_0 11'h200
`define HALF_PERIOD_1 11'h156
`define HALF_PERIOD_2 11'h100
`define HALF_PERIOD_3 11'h0CD
`define BLANK_W 2
`define BLANK_CYCLES_0 11'h010
`define BLANK_CYCLES_1 11'h018
`define BLANK_CYCLES_2 11'h024
`define BLANK_CYCLES_3 11'h036
`define CUR_W 8
`define ERR_W 17
`define STILL_PERIODS 8'h80
`define CLK_PERIOD_NS 100

`endif

// file: hdl/pwm_regulator_pkg.sv
/*
 * Types of the voltage PWM amplitude regulator.
 * Assumes the cfg header is compiled alongside.
 */
package pwm_regulator_pkg;

    typedef enum logic [1:0]
    {
        MODE_OFF,
        MODE_CURRENT,
        MODE_VOLTAGE
    } chop_mode_e;

endpackage : pwm_regulator_pkg

// file: sim/coil_model.sv
/* coil pair with sense resistor: sensed current follows the scale
   assumes the regulator clock and its carrier on-phase */
`timescale 1ns/10ps
`include "pwm_regulator_cfg.svh"
module coil_model
(
    // clock
    input wire logic clk,
    // drive
    input wire logic pwm_on,
    input wire logic [`SCALE_W-1:0] pwm_scale,
    // sense
    output logic [`CUR_W-1:0] coil_current
);
    // slow decay bypasses the resistor, so nothing is sensed while off
    always_ff @(posedge clk)
        coil_current <= pwm_on ? {3'h0, pwm_scale[7:3]} : 8'h00;
endmodule : coil_model

// file: sim/pwm_regulator_monitor.sv
/* assertions on the amplitude regulator ports
   bound below to every pwm_amplitude_regulator */
`timescale 1ns/10ps
`include "pwm_regulator_cfg.svh"
module pwm_regulator_monitor
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // configuration and motion
    input wire logic pwm_autoscale,
    input wire logic [`GRAD_W-1:0] regulation_gradient,
    input wire logic [`SCALE_W-1:0] user_pwm_amplitude,
    input wire logic [`FREQ_W-1:0] pwm_frequency_select,
    input wire logic below_switch_velocity,
    input wire logic standstill,
    // status
    input wire logic [`SCALE_W-1:0] pwm_scale,
    input wire logic [`SCALE_W-1:0] sine_peak,
    input wire logic voltage_mode_active,
    input wire logic regulation_started,
    input wire logic period_tick
);
    logic [10:0] gap_q;
    logic [10:0] want;
    logic steady_q;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // period only judged when the select held for the whole period
    always_ff @(posedge clk)
    begin
        gap_q <= period_tick ? 11'h001 : gap_q + 11'h001;
        steady_q <= rst_n & (period_tick
            | steady_q & $stable(pwm_frequency_select));
    end
    always_comb
        case (pwm_frequency_select)
            2'h0: want = `HALF_PERIOD_0;
            2'h1: want = `HALF_PERIOD_1;
            2'h2: want = `HALF_PERIOD_2;
            default: want = `HALF_PERIOD_3;
        endcase
    sequence s_enabled;
        regulation_gradient != `GRAD_OFF && below_switch_velocity;
    endsequence
    sequence s_reentry;
        !voltage_mode_active ##1 voltage_mode_active;
    endsequence
    chk_sine_peak: assert property (sine_peak == `SINE_PEAK)
        else $error("sine peak wrong");
    chk_mode_enable: assert property (s_enabled |=> voltage_mode_active)
        else $error("voltage mode not entered");
    chk_grad_off: assert property (regulation_gradient == `GRAD_OFF
        |=> !voltage_mode_active) else $error("gradient zero ignored");
    chk_above_off: assert property (!below_switch_velocity |=> !voltage_mode_active)
        else $error("voltage mode above switch");
    chk_reentry_load: assert property (s_reentry |-> pwm_scale == $past(user_pwm_amplitude))
        else $error("reentry scale wrong");
    chk_fixed_amp: assert property ((!pwm_autoscale && voltage_mode_active)[*2]
        |-> pwm_scale == $past(user_pwm_amplitude)) else $error("fixed scale wrong");
    chk_start_still: assert property ($rose(regulation_started)
        |-> $past(standstill) && $past(pwm_autoscale)) else $error("start in motion");
    chk_frozen_above: assert property (!voltage_mode_active[*2] |-> $stable(pwm_scale))
        else $error("scale moved while inactive");
    // a full carrier period is an up sweep and a down sweep of the counter
    chk_period_len: assert property (period_tick && steady_q |-> gap_q == (want << 1))
        else $error("carrier period wrong");
endmodule : pwm_regulator_monitor
bind pwm_amplitude_regulator pwm_regulator_monitor mon
(
    .clk, .rst_n, .pwm_autoscale, .regulation_gradient, .user_pwm_amplitude,
    .pwm_frequency_select, .below_switch_velocity, .standstill, .pwm_scale,
    .sine_peak, .voltage_mode_active, .regulation_started, .period_tick
);

// file: sim/test_voltage_pwm_amplitude_regulator.sv
/* bench of the amplitude regulator against the coil model
   inputs move 10 ns after each rising edge */
`timescale 1ns/10ps
`include "pwm_regulator_cfg.svh"
module test_voltage_pwm_amplitude_regulator;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic autoscale = 1'b0;
    logic below = 1'b1;
    logic still = 1'b1;
    logic [`GRAD_W-1:0] grad = 4'h0;
    logic [`SCALE_W-1:0] ampl = 8'h5A;
    logic [`FREQ_W-1:0] fsel = 2'h3;
    logic [`BLANK_W-1:0] bsel = 2'h0;
    logic [`CUR_W-1:0] target = 8'h14;
    logic [`CUR_W-1:0] cur;
    logic [`SCALE_W-1:0] scale;
    logic [`SCALE_W-1:0] peak;
    logic [`SCALE_W-1:0] keep;
    logic vmode;
    logic started;
    logic pon;
    logic tick;
    int bad_count = 0;
    int check_count = 0;
    int cycles = 0;
    pwm_amplitude_regulator dut
    (
        .clk(clk), .rst_n(rst_n), .pwm_autoscale(autoscale),
        .regulation_gradient(grad), .user_pwm_amplitude(ampl),
        .pwm_frequency_select(fsel), .blank_time_select(bsel),
        .below_switch_velocity(below), .standstill(still),
        .coil_current(cur), .target_current(target), .pwm_scale(scale),
        .sine_peak(peak), .voltage_mode_active(vmode),
        .regulation_started(started), .pwm_on(pon), .period_tick(tick)
    );
    coil_model coil
    (
        .clk(clk), .pwm_on(pon), .pwm_scale(scale), .coil_current(cur)
    );
    always #50 clk = ~clk;
    task automatic tally_and_finish(input int extra);
        bad_count += extra;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish
    // run needs about 16k cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 60000)
            tally_and_finish(1);
    end
    task automatic tick_n(input int n);
        repeat (n) @(posedge clk);
        #10;
    endtask : tick_n
    task automatic check(input string what, input logic [7:0] exp,
        input logic [7:0] seen);
        check_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    initial
    begin
        tick_n(2);
        check("peak", `SINE_PEAK, peak);
        check("reset scale", `SCALE_RESET, scale);
        rst_n = 1'b1;
        tick_n(1);
        grad = 4'h4;
        tick_n(3);
        check("mode", 8'h01, {7'h0, vmode});
        check("fixed", 8'h5A, scale);
        ampl = 8'hC3;
        tick_n(3);
        check("fixed", 8'hC3, scale);
        grad = `GRAD_OFF;
        tick_n(2);
        check("off", 8'h00, {7'h0, vmode});
        ampl = 8'h40;
        grad = 4'h4;
        tick_n(2);
        check("reentry", 8'h40, scale);
        autoscale = 1'b1;
        while (scale === 8'h40)
            tick_n(1);
        check("first step", 8'h70, scale);
        tick_n(4100);
        check("settled", 8'h01, {7'h0, scale >= 8'hA0 && scale <= 8'hA7});
        keep = scale;
        still = 1'b0;
        below = 1'b0;
        tick_n(2);
        check("above", 8'h00, {7'h0, vmode});
        tick_n(600);
        check("frozen", keep, scale);
        ampl = 8'hC0;
        below = 1'b1;
        tick_n(1);
        check("reentry", 8'hC0, scale);
        still = 1'b1;
        target = 8'hFF;
        grad = 4'hF;
        tick_n(3000);
        check("saturated", `SCALE_MAX, scale);
        still = 1'b0;
        target = 8'h14;
        grad = 4'h4;
        rst_n = 1'b0;
        tick_n(2);
        rst_n = 1'b1;
        tick_n(400);
        check("no start", 8'h00, {7'h0, started});
        still = 1'b1;
        tick_n(3);
        check("start", 8'h01, {7'h0, started});
        for (int c = 0; c < 4; c++)
        begin
            fsel = 2'(c);
            bsel = 2'(c);
            repeat (3) @(posedge clk iff tick);
            tick_n(1);
        end
        tally_and_finish(0);
    end
endmodule : test_voltage_pwm_amplitude_regulator
